// ===== shared/osf_pkg.sv
`default_nettype none
package osf_pkg;
  localparam int unsigned CHANNELS  = 8;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned MAX_SHIFT = 6;                 // ratio 64
  localparam int unsigned ACC_W     = DATA_W + MAX_SHIFT;
  localparam int unsigned CNT_W     = 7;                 // counts up to 64 samples
  localparam int unsigned OS_W      = 3;
  localparam int unsigned IDX_W     = 3;

  // select field codes
  localparam logic [OS_W-1:0] OS_NONE    = 3'h0;
  localparam logic [OS_W-1:0] OS_INVALID = 3'h7;
  localparam logic [OS_W-1:0] OS_RESET   = OS_NONE;

  // spacing of internally timed samples: one base-rate period
  localparam int unsigned CLK_PERIOD_PS = 5000;          // 200 MHz
  localparam int unsigned SAMPLE_GAP_NS = 5000;          // 200k samples per second
  localparam int unsigned GAP_CYCLES    = (SAMPLE_GAP_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned TMR_W         = 10;
  localparam logic [TMR_W-1:0] GAP_LOAD = TMR_W'(GAP_CYCLES - 1);

  typedef logic [CHANNELS-1:0][DATA_W-1:0] osf_bank_t;

  // code to log2 of the ratio; 111 is not a ratio and runs without averaging
  function automatic logic [OS_W-1:0] osf_shift(input logic [OS_W-1:0] code);
    osf_shift = (code == OS_INVALID) ? OS_NONE : code;
  endfunction

  // number of samples per channel for a code
  function automatic logic [CNT_W-1:0] osf_count(input logic [OS_W-1:0] code);
    osf_count = CNT_W'(1) << osf_shift(code);
  endfunction
endpackage
`default_nettype wire

// ===== shared/osf_acc_if.sv
`default_nettype none
interface osf_acc_if;
  logic                      clear;    // start of an oversampled conversion
  logic                      add;      // fold one set of samples in
  osf_pkg::osf_bank_t        samples;
  logic [osf_pkg::OS_W-1:0]  shift;    // log2 of the ratio in use
  osf_pkg::osf_bank_t        avg;      // averaged, decimated results

  modport ctrl (output clear, output add, output samples, output shift, input avg);
  modport core (input clear, input add, input samples, input shift, output avg);
endinterface
`default_nettype wire

// ===== design/osf_avg_core.sv
`default_nettype none
module osf_avg_core (
  input  wire logic  ref_clk,
  input  wire logic  arst_n,
  osf_acc_if.core    acc_if
);
  typedef struct packed {
    logic [osf_pkg::CHANNELS-1:0][osf_pkg::ACC_W-1:0] acc;
  } osf_core_state_t;

  osf_core_state_t state;
  osf_core_state_t next_state;

  // [RULE_09] running sum per channel
  always_comb
  begin
    next_state = state;
    for (int c = 0; c < osf_pkg::CHANNELS; c++)
    begin
      if (acc_if.clear)
        next_state.acc[c] = '0;
      else if (acc_if.add)
        next_state.acc[c] = state.acc[c]
          + {{osf_pkg::MAX_SHIFT{acc_if.samples[c][osf_pkg::DATA_W-1]}}, acc_if.samples[c]};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= '0;
    else
      state <= next_state;
  end

  // [RULE_10] divide by ratio, keep 16 bits
  generate
    for (genvar g = 0; g < osf_pkg::CHANNELS; g++)
    begin : g_avg
      logic signed [osf_pkg::ACC_W-1:0] scaled;
      assign scaled = $signed(state.acc[g]) >>> acc_if.shift;
      assign acc_if.avg[g] = scaled[osf_pkg::DATA_W-1:0]; // sum of N fits 16 bits after shift
    end
  endgenerate

  a_clear_zero: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_09
    acc_if.clear |=> state.acc[0] == '0 && state.acc[osf_pkg::CHANNELS-1] == '0)
    else $error("accumulator not cleared");

  a_add_sum: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_09
    acc_if.add && !acc_if.clear |=> state.acc[0] == $past(state.acc[0])
      + {{osf_pkg::MAX_SHIFT{$past(acc_if.samples[0][osf_pkg::DATA_W-1])}},
         $past(acc_if.samples[0])})
    else $error("accumulator sum wrong");
endmodule
`default_nettype wire

// ===== design/osf_filter.sv
// Overview of operation
// [RULE_01] results readable while busy is high
// [RULE_02] read-out same for every mode and ratio
// [RULE_03] output registers load as busy falls
// [RULE_04] three select pins, bit 2 most significant
// [RULE_05] select pins captured as busy falls
// [RULE_06] codes 000 none, 001-110 ratio 2-64
// [RULE_07] host keeps start rate within ratio limit
// [RULE_08] first sample on start, rest internally timed
// [RULE_09] all samples per channel are averaged
// [RULE_10] average decimated to a 16-bit word
// [RULE_11] host drives both start inputs together; without a ratio either input alone starts a conversion
// [RULE_12] busy spans the whole oversampled conversion
// [RULE_13] host should read during busy for throughput
// [RULE_14] reads step through channels from channel 1
// [RULE_15] busy rises at start, falls after averaging
`default_nettype none
module osf_filter (
  input  wire logic                         ref_clk,
  input  wire logic                         arst_n,
  input  wire logic                         convert_start_a,
  input  wire logic                         convert_start_b,
  input  wire logic [osf_pkg::OS_W-1:0]     oversample_select,
  input  wire logic                         read_n,
  input  wire logic                         conv_done,
  input  wire osf_pkg::osf_bank_t           conv_data,
  output logic                              sample_start,
  output logic                              busy,
  output logic [osf_pkg::DATA_W-1:0]        data_out,
  output logic                              first_channel
);
  typedef enum logic [1:0] {OSF_IDLE, OSF_CONV, OSF_GAP, OSF_FINISH} osf_phase_t;

  typedef struct packed {
    osf_phase_t                 phase;
    logic                       busy;
    logic                       sample_start;
    logic [osf_pkg::OS_W-1:0]   os_cur;
    logic [osf_pkg::CNT_W-1:0]  taken;
    logic [osf_pkg::TMR_W-1:0]  timer;
    logic [osf_pkg::IDX_W-1:0]  rd_idx;
    osf_pkg::osf_bank_t         out_reg;
    logic [osf_pkg::DATA_W-1:0] data_out;
    logic                       first_channel;
    logic [1:0]                 cs_a_sync;
    logic [1:0]                 cs_b_sync;
    logic [1:0]                 rd_sync;
    logic [osf_pkg::OS_W-1:0]   os_s1;
    logic [osf_pkg::OS_W-1:0]   os_s2;
    logic                       start_prev;
    logic                       rd_prev;
  } osf_state_t;

  osf_state_t state;
  osf_state_t next_state;
  osf_acc_if  acc_if ();

  logic start_level;
  logic start_edge;
  logic rd_fall;

  // [RULE_11] with a ratio set both inputs must be high; without one either may start
  assign start_level = (osf_pkg::osf_shift(state.os_cur) != osf_pkg::OS_NONE)
                     ? (state.cs_a_sync[1] & state.cs_b_sync[1])
                     : (state.cs_a_sync[1] | state.cs_b_sync[1]);
  assign start_edge  = start_level & ~state.start_prev;
  assign rd_fall     = state.rd_prev & ~state.rd_sync[1];

  // accumulator hookup
  assign acc_if.clear   = (state.phase == OSF_IDLE) && start_edge;
  assign acc_if.add     = (state.phase == OSF_CONV) && conv_done;
  assign acc_if.samples = conv_data;
  // [RULE_06] code to ratio, 111 runs unaveraged
  assign acc_if.shift   = osf_pkg::osf_shift(state.os_cur);

  osf_avg_core u_core (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .acc_if  (acc_if)
  );

  // pin synchronisers, phase sequencing and read-out
  always_comb
  begin
    next_state = state;
    next_state.cs_a_sync    = {state.cs_a_sync[0], convert_start_a};
    next_state.cs_b_sync    = {state.cs_b_sync[0], convert_start_b};
    next_state.rd_sync      = {state.rd_sync[0], read_n};
    // [RULE_04] select pins, bit 2 most significant
    next_state.os_s1        = oversample_select;
    next_state.os_s2        = state.os_s1;
    next_state.start_prev   = start_level;
    next_state.rd_prev      = state.rd_sync[1];
    next_state.sample_start = 1'b0;
    if (state.timer != '0)
      next_state.timer = state.timer - 1'b1;

    // [RULE_02] one read path for every read-out mode
    // [RULE_01] reads serve the held bank, so a read during busy sees the previous results
    // [RULE_14] each read strobe presents the next channel, channel 1 first
    if (rd_fall)
    begin
      next_state.data_out      = state.out_reg[state.rd_idx];
      next_state.first_channel = (state.rd_idx == '0);
      next_state.rd_idx        = state.rd_idx + 1'b1;
    end

    case (state.phase)
      OSF_IDLE:
      begin
        // [RULE_15] busy rises with the start edge
        // [RULE_08] the start edge takes the first sample
        if (start_edge)
        begin
          next_state.busy         = 1'b1;
          next_state.sample_start = 1'b1;
          next_state.taken        = osf_pkg::CNT_W'(1);
          next_state.timer        = osf_pkg::GAP_LOAD;
          next_state.phase        = OSF_CONV;
        end
      end
      OSF_CONV:
      begin
        // [RULE_12] busy held until the last of N samples is in
        if (conv_done)
          next_state.phase = (state.taken == osf_pkg::osf_count(state.os_cur))
                           ? OSF_FINISH : OSF_GAP;
      end
      OSF_GAP:
      begin
        // [RULE_08] remaining samples paced by the internal timer
        if (state.timer == '0)
        begin
          next_state.sample_start = 1'b1;
          next_state.taken        = state.taken + 1'b1;
          next_state.timer        = osf_pkg::GAP_LOAD;
          next_state.phase        = OSF_CONV;
        end
      end
      OSF_FINISH:
      begin
        // [RULE_03] new bank loads as busy falls; a colliding read gets the old bank and its index step is overridden
        // [RULE_05] select pins captured for the next conversion
        next_state.busy    = 1'b0;
        next_state.out_reg = acc_if.avg;
        next_state.os_cur  = state.os_s2;
        next_state.rd_idx  = '0;
        next_state.phase   = OSF_IDLE;
      end
      default:
        next_state.phase = OSF_IDLE;
    endcase
  end

  // one register for the whole state; select defaults to no oversampling
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state        <= '0;
      state.phase  <= OSF_IDLE;
      state.os_cur <= osf_pkg::OS_RESET;
      state.rd_sync <= 2'h3;
      state.rd_prev <= 1'b1;
    end
    else
      state <= next_state;
  end

  assign sample_start  = state.sample_start;
  assign busy          = state.busy;
  assign data_out      = state.data_out;
  assign first_channel = state.first_channel;

  // helper: samples taken in the current conversion
  logic [osf_pkg::CNT_W-1:0] seen;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      seen <= '0;
    else if (acc_if.clear)
      seen <= '0;
    else if (acc_if.add)
      seen <= seen + 1'b1;
  end

  a_busy_rise: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_15
    state.phase == OSF_IDLE && start_edge |=> busy && sample_start)
    else $error("busy did not rise on start");

  a_ratio_samples: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_12
    $fell(busy) |-> seen == osf_pkg::osf_count($past(state.os_cur)))
    else $error("wrong number of samples averaged");

  a_load_at_fall: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_03
    $changed(state.out_reg) |-> $fell(busy) && state.rd_idx == '0)
    else $error("output bank changed outside busy fall");

  a_os_capture: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_05
    $fell(busy) |-> state.os_cur == $past(state.os_s2))
    else $error("select not captured at busy fall");

  a_os_hold: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_05
    !$fell(busy) |-> $stable(state.os_cur))
    else $error("select changed outside busy fall");

  a_read_step: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_14
    rd_fall && state.phase != OSF_FINISH |=>
      state.rd_idx == $past(state.rd_idx) + 1'b1 &&
      data_out == $past(state.out_reg[state.rd_idx]))
    else $error("read did not step channel");

  a_sample_gap: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_08
    sample_start |=> !sample_start [*8])
    else $error("internal samples too close");
endmodule
`default_nettype wire

// ===== test/osf_conv_model.sv
`default_nettype none
module osf_conv_model (
  input  wire logic               ref_clk,
  input  wire logic               busy,
  input  wire logic               sample_start,
  input  wire logic [7:0]         lat,
  input  wire osf_pkg::osf_bank_t base,
  output logic                    conv_done,
  output osf_pkg::osf_bank_t      conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int                 k;
  osf_pkg::osf_bank_t last;

  // idle outputs before the first request
  initial
  begin
    k         = 0;
    last      = '0;
    conv_done = 1'b0;
    conv_data = '1;
  end

  // answer each request after lat cycles; sample index restarts between conversions
  always @(posedge ref_clk)
  begin
    if (!busy)
      k = 0;
    if (sample_start)
    begin
      repeat (lat) @(posedge ref_clk);
      for (int c = 0; c < osf_pkg::CHANNELS; c++)
        last[c] = base[c] + 16'(k);
      conv_data <= last;
      conv_done <= 1'b1;
      @(posedge ref_clk);
      conv_done <= 1'b0;
      // data only counts with the strobe, so show junk otherwise
      conv_data <= ~last;
      k++;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                         ref_clk;
  logic                         arst_n;
  logic                         convert_start_a;
  logic                         convert_start_b;
  logic [osf_pkg::OS_W-1:0]     oversample_select;
  logic                         read_n;
  logic                         conv_done;
  osf_pkg::osf_bank_t           conv_data;
  logic                         sample_start;
  logic                         busy;
  logic [osf_pkg::DATA_W-1:0]   data_out;
  logic                         first_channel;
  logic [7:0]                   lat;
  osf_pkg::osf_bank_t           base;
  osf_pkg::osf_bank_t           prev;
  logic [2:0]                   cur;
  logic [2:0]                   codes [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7, 3'h0};
  int                           n_errors;
  int                           compares;
  int                           cycles;
  int                           n_smp;
  int                           n_busy;
  int                           seed;

  osf_filter osf_filter_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .convert_start_a(convert_start_a), .convert_start_b(convert_start_b),
    .oversample_select(oversample_select), .read_n(read_n), .conv_done(conv_done),
    .conv_data(conv_data), .sample_start(sample_start), .busy(busy),
    .data_out(data_out), .first_channel(first_channel));

  osf_conv_model osf_conv_model_inst (.ref_clk(ref_clk), .busy(busy),
    .sample_start(sample_start), .lat(lat), .base(base), .conv_done(conv_done),
    .conv_data(conv_data));

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  // cycle ceiling, sample requests and busy length
  always @(posedge ref_clk)
  begin
    cycles++;
    if (sample_start === 1'b1)
      n_smp++;
    if (busy === 1'b1)
      n_busy++;
    if (cycles == 110000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // average of all samples per channel, arithmetic shift keeps the sign
  function automatic osf_pkg::osf_bank_t expect_bank(input osf_pkg::osf_bank_t b,
                                                     input logic [2:0] code);
    logic signed [osf_pkg::ACC_W-1:0] acc;
    logic [15:0]                      s;
    int                               sh;
    osf_pkg::osf_bank_t               r;
    sh = (code == 3'h7) ? 0 : int'(code);
    for (int c = 0; c < 8; c++)
    begin
      acc = '0;
      for (int k = 0; k < (1 << sh); k++)
      begin
        s   = b[c] + 16'(k);
        acc = acc + {{osf_pkg::MAX_SHIFT{s[15]}}, s};
      end
      r[c] = 16'(acc >>> sh);
    end
    return r;
  endfunction

  // nine reads from index first; the index wraps after the last channel
  task automatic read_all(input osf_pkg::osf_bank_t b, input int first);
    for (int i = 0; i < 9; i++)
    begin
      read_n = 1'b0;
      repeat (5) @(negedge ref_clk);
      check(data_out, b[(first + i) % 8]);
      check(first_channel, (first + i) % 8 == 0);
      read_n = 1'b1;
      repeat (5) @(negedge ref_clk);
    end
  endtask

  task automatic run(input logic [2:0] nxt, input bit a_only);
    osf_pkg::osf_bank_t exp;
    int                 n;
    int                 w;
    int                 t0;
    oversample_select = nxt;
    for (int c = 0; c < 8; c++)
      base[c] = 16'($random(seed));
    lat    = 8'(1 + {$random(seed)} % 12);
    exp    = expect_bank(base, cur);
    n      = (cur == 3'h7) ? 1 : (1 << cur);
    n_smp  = 0;
    n_busy = 0;
    t0     = cycles;
    convert_start_a = 1'b1;
    convert_start_b = !a_only;
    w = 0;
    while (busy !== 1'b1 && w < 6)
    begin
      @(negedge ref_clk);
      w++;
    end
    check(busy, 1'b1);
    convert_start_a = 1'b0;
    convert_start_b = 1'b0;
    if (n > 1)
    begin
      // read while busy
      // the nine reads after the last busy fall left the index on channel 2
      read_all(prev, 1);
      convert_start_a = 1'b1;
      convert_start_b = 1'b1;
      repeat (10) @(negedge ref_clk);
      convert_start_a = 1'b0;
      convert_start_b = 1'b0;
    end
    w = 0;
    while (busy !== 1'b0 && w < 70000)
    begin
      @(negedge ref_clk);
      w++;
    end
    check(n_smp, n);
    check(n_busy >= (n - 1) * osf_pkg::GAP_CYCLES, 1);
    // busy spans the internal gaps, the model latency and three edges of handshake
    check(n_busy, (n - 1) * osf_pkg::GAP_CYCLES + lat + 3);
    // reads kept off the busy fall
    read_all(exp, 0);
    // start spacing kept within the ratio's rate
    while (cycles - t0 < n * int'(osf_pkg::GAP_CYCLES))
      @(negedge ref_clk);
    prev = exp;
    cur  = nxt;
  endtask

  // each run starts after the previous busy falls; runs with a ratio also pulse both starts during busy
  initial
  begin
    seed              = 32'h46ad048a;
    ref_clk           = 1'b0;
    arst_n            = 1'b0;
    convert_start_a   = 1'b0;
    convert_start_b   = 1'b0;
    oversample_select = 3'h0;
    read_n            = 1'b1;
    lat               = 8'h1;
    base              = '0;
    prev              = '0;
    cur               = 3'h0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    check(busy, 1'b0);
    check(data_out, 16'h0000);
    @(negedge ref_clk);
    foreach (codes[i])
      run(codes[i], i == 0);
    conclude();
  end
endmodule
`default_nettype wire
